// >>> rtl/fci_pkg.sv
// constants for the flash command interlock
// assumes a 40 mhz system clock and 32-bit avalon-mm register access
package fci_pkg;
   // register byte addresses
   localparam logic [3:0] ADDR_CTRL0   = 4'h0;
   localparam logic [3:0] ADDR_CMD     = 4'h4;
   localparam logic [3:0] ADDR_PMODE1  = 4'h8;
   localparam logic [3:0] ADDR_IRQ_ST  = 4'hc;
   localparam logic [3:0] ADDR_IRQ_MSK = 4'h0;
   localparam logic [4:0] ADDR_MSK     = 5'h10;
   localparam logic [4:0] ADDR_CYC     = 5'h14;

   // flash_control_reg0 fields
   localparam int BIT_READY  = 0;
   localparam int BIT_RWEN   = 1;
   localparam int BIT_SLOW   = 2;
   localparam int BIT_LOWCUR = 3;
   localparam int BIT_PERR   = 6;
   localparam int BIT_EERR   = 7;

   // processor_mode_reg1 fields
   localparam int BIT_AREA_SEL = 0;
   localparam int BIT_AREA_EXP = 3;

   // interrupt status fields
   localparam int IRQ_DONE  = 0;
   localparam int IRQ_ABORT = 1;
   localparam int IRQ_ERR   = 2;
   localparam int IRQ_W     = 3;

   // command codes written to the command register
   localparam logic [2:0] CMD_PROGRAM   = 3'h1;
   localparam logic [2:0] CMD_ERASE     = 3'h2;
   localparam logic [2:0] CMD_LOCK_PROG = 3'h3;
   localparam logic [2:0] CMD_LOCK_READ = 3'h4;
   localparam logic [2:0] CMD_BLANK     = 3'h5;
   localparam logic [2:0] CMD_CLR_STAT  = 3'h6;

   // operation timing; program and erase times grow with wear, the short time does not
   localparam int CLK_MHZ       = 40;
   localparam int T_PROG_US     = 10;
   localparam int T_ERASE_US    = 20;
   localparam int T_SHORT_US    = 2;
   localparam int PROG_CYC      = T_PROG_US * CLK_MHZ;
   localparam int ERASE_CYC     = T_ERASE_US * CLK_MHZ;
   localparam int SHORT_CYC     = T_SHORT_US * CLK_MHZ;
   localparam int WEAR_SHIFT    = 4;
   localparam int CNT_W         = 24;
   localparam int WEAR_W        = 16;

   typedef enum logic [1:0] {FCI_IDLE, FCI_BUSY} fci_state_e;
endpackage

// >>> rtl/fci_sticky.sv
// one sticky event bit, cleared by writing one
// assumes set and clear are single-cycle pulses in the system clock domain
`timescale 1ns/1ps
module fci_sticky (
   // clock and reset
   input  wire logic clock_in,
   input  wire logic rst_b_in,
   // control
   input  wire logic set_in,
   input  wire logic clr_in,
   // state
   output logic      flag_out
);
   // set beats clear so an event in the clear cycle survives
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flag_out <= 1'b0;
      end else if (set_in) begin
         flag_out <= 1'b1;
      end else if (clr_in) begin
         flag_out <= 1'b0;
      end
   end
endmodule

// >>> rtl/fci_top.sv
// flash command interlock: busy/error flags, forced mode bits, abort
// assumes one avalon-mm master; resets and abort interrupts are sync pulses
//
// Contract
// - ready flag reads 0 while any flash command is executing
// - rewrite enable forces area expansion to 1, restores prior value
// - area expansion write in rewrite mode held until rewrite cleared
// - rewrite mode also forces area access select to 1
// - busy time grows with accumulated program/erase cycles
// - any system reset source aborts an operation in progress
// - nmi, watchdog, osc, voltage monitor interrupts abort operations
// - clear status command resets both error flags to 0
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module fci_top
   import fci_pkg::*;
(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_b_in,
   // avalon-mm slave
   input  wire logic [4:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   // system reset sources and abort interrupts
   input  wire logic        sys_reset_pulse_in,
   input  wire logic        abort_irq_in,
   // flash array result
   input  wire logic        array_fail_in,
   // forced mode bits, busy and interrupt to the cpu
   output logic             area_expansion_out,
   output logic             area_access_sel_out,
   output logic             busy_out,
   output logic             irq_out
);
   fci_state_e        state_q;
   logic [2:0]        cmd_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [WEAR_W-1:0] wear_q;
   logic              rwen_q;
   logic              slow_q;
   logic              lowcur_q;
   logic              perr_q;
   logic              eerr_q;
   logic              exp_user_q;
   logic              sel_user_q;
   logic [IRQ_W-1:0]  msk_q;
   logic [IRQ_W-1:0]  st;
   logic [31:0]       rdata_d;
   logic [31:0]       rdata_q;
   logic              rd_ack_q;
   logic              wr_en;
   logic              cmd_wr;
   logic              abort;
   logic              finish;
   logic              fail;
   logic [CNT_W-1:0]  dur;
   logic [IRQ_W-1:0]  ev_set;
   logic [IRQ_W-1:0]  ev_clr;

   // writes complete in one cycle, reads stall one cycle for registered data
   assign avs_waitrequest_out = avs_read_in & ~rd_ack_q;
   assign wr_en               = avs_write_in & avs_byteenable_in[0];
   assign cmd_wr              = wr_en && (avs_address_in == {1'b0, ADDR_CMD});
   assign abort  = sys_reset_pulse_in | abort_irq_in;
   assign finish = (state_q == FCI_BUSY) && (cnt_q == '0);
   assign fail   = finish & array_fail_in;

   always_comb begin
      unique case (avs_writedata_in[2:0])
         CMD_PROGRAM, CMD_LOCK_PROG:
            dur = CNT_W'(PROG_CYC) + CNT_W'(wear_q >> WEAR_SHIFT);
         CMD_ERASE:
            dur = CNT_W'(ERASE_CYC) + CNT_W'(wear_q >> WEAR_SHIFT);
         default:
            dur = CNT_W'(SHORT_CYC);
      endcase
   end

   // busy from command start until done or abort
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q <= FCI_IDLE;
         cnt_q   <= '0;
         cmd_q   <= 3'h0;
      end else begin
         unique case (state_q)
            FCI_IDLE: begin
               if (cmd_wr && !abort && (avs_writedata_in[2:0] != CMD_CLR_STAT)
                   && (avs_writedata_in[2:0] != 3'h0)
                   && (avs_writedata_in[2:0] != 3'h7)) begin
                  state_q <= FCI_BUSY;
                  cnt_q   <= dur;
                  cmd_q   <= avs_writedata_in[2:0];
               end
            end
            FCI_BUSY: begin
               if (abort || finish) begin
                  state_q <= FCI_IDLE;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
         endcase
      end
   end

   // wear counter of completed program/erase operations
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wear_q <= '0;
      end else if (finish && !abort && (cmd_q == CMD_PROGRAM || cmd_q == CMD_ERASE)
                   && (wear_q != '1)) begin
         wear_q <= wear_q + 1'b1;
      end
   end

   // error flags: failure set wins over clear status
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         perr_q <= 1'b0;
         eerr_q <= 1'b0;
      end else begin
         if (fail && (cmd_q == CMD_PROGRAM || cmd_q == CMD_LOCK_PROG)) begin
            perr_q <= 1'b1;
         end else if (cmd_wr && state_q == FCI_IDLE
                      && avs_writedata_in[2:0] == CMD_CLR_STAT) begin
            perr_q <= 1'b0;
         end
         if (fail && (cmd_q == CMD_ERASE || cmd_q == CMD_BLANK)) begin
            eerr_q <= 1'b1;
         end else if (cmd_wr && state_q == FCI_IDLE
                      && avs_writedata_in[2:0] == CMD_CLR_STAT) begin
            eerr_q <= 1'b0;
         end
      end
   end

   // control bits written by software
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rwen_q   <= 1'b0;
         slow_q   <= 1'b0;
         lowcur_q <= 1'b0;
      end else if (wr_en && avs_address_in == {1'b0, ADDR_CTRL0}) begin
         rwen_q   <= avs_writedata_in[BIT_RWEN];
         slow_q   <= avs_writedata_in[BIT_SLOW];
         lowcur_q <= avs_writedata_in[BIT_LOWCUR];
      end
   end

   // user value stored; only visible once rewrite mode ends
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         exp_user_q <= 1'b0;
         sel_user_q <= 1'b0;
      end else if (wr_en && avs_address_in == {1'b0, ADDR_PMODE1}) begin
         exp_user_q <= avs_writedata_in[BIT_AREA_EXP];
         sel_user_q <= avs_writedata_in[BIT_AREA_SEL];
      end
   end

   assign area_expansion_out  = rwen_q | exp_user_q;
   assign area_access_sel_out = rwen_q | sel_user_q;
   assign busy_out            = (state_q == FCI_BUSY);

   // interrupt events: done, aborted, error
   assign ev_set[IRQ_DONE]  = finish & ~abort;
   assign ev_set[IRQ_ABORT] = abort & (state_q == FCI_BUSY);
   assign ev_set[IRQ_ERR]   = fail & ~abort;

   generate
      for (genvar i = 0; i < IRQ_W; i++) begin : g_st
         assign ev_clr[i] = wr_en && (avs_address_in == {1'b0, ADDR_IRQ_ST})
                            && avs_writedata_in[i];
         fci_sticky u_st (
            .clock_in (clock_in),
            .rst_b_in (rst_b_in),
            .set_in   (ev_set[i]),
            .clr_in   (ev_clr[i]),
            .flag_out (st[i])
         );
      end
   endgenerate

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         msk_q <= '0;
      end else if (wr_en && avs_address_in == ADDR_MSK) begin
         msk_q <= avs_writedata_in[IRQ_W-1:0];
      end
   end

   assign irq_out = |(st & msk_q);

   // read mux
   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (avs_address_in)
         {1'b0, ADDR_CTRL0}: begin
            rdata_d[BIT_READY]  = (state_q == FCI_IDLE);
            rdata_d[BIT_RWEN]   = rwen_q;
            rdata_d[BIT_SLOW]   = slow_q;
            rdata_d[BIT_LOWCUR] = lowcur_q;
            rdata_d[BIT_PERR]   = perr_q;
            rdata_d[BIT_EERR]   = eerr_q;
         end
         {1'b0, ADDR_PMODE1}: begin
            rdata_d[BIT_AREA_EXP] = area_expansion_out;
            rdata_d[BIT_AREA_SEL] = area_access_sel_out;
         end
         {1'b0, ADDR_IRQ_ST}: rdata_d[IRQ_W-1:0] = st;
         ADDR_MSK:            rdata_d[IRQ_W-1:0] = msk_q;
         ADDR_CYC:            rdata_d[WEAR_W-1:0] = wear_q;
         default:             rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_ack_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
      end else begin
         rd_ack_q <= avs_read_in & ~rd_ack_q;
         if (avs_read_in & ~rd_ack_q) begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign avs_readdata_out = rdata_q;
endmodule

// >>> testbench/fci_props.sv
// checker: interlock properties seen at the fci_top ports
// assumes bound to fci_top; one clock domain
`timescale 1ns/1ps
module fci_props (
   // clock, reset, bus
   input wire logic        clock_in,
   input wire logic        rst_b_in,
   input wire logic [4:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0]  avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   // aborts, mode bits and busy
   input wire logic        sys_reset_pulse_in,
   input wire logic        abort_irq_in,
   input wire logic        area_expansion_out,
   input wire logic        area_access_sel_out,
   input wire logic        busy_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   logic rwen_q, exp_q, sel_q, clr_q;
   wire  wr_ok = avs_write_in && avs_byteenable_in[0];
   wire  rd_ok = avs_read_in && !avs_waitrequest_out;
   // shadow of the software-written bits, so held writes can be predicted
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         {rwen_q, exp_q, sel_q, clr_q} <= 4'h0;
      end else if (wr_ok) begin
         if (avs_address_in == 5'h00) rwen_q <= avs_writedata_in[1];
         if (avs_address_in == 5'h08) {exp_q, sel_q} <= {avs_writedata_in[3], avs_writedata_in[0]};
         if (avs_address_in == 5'h04 && !busy_out) clr_q <= avs_writedata_in[2:0] == 3'h6;
      end
   end
   sequence s_cmd;
      wr_ok && avs_address_in == 5'h04 && avs_writedata_in[2:0] inside {[3'h1:3'h5]} && !busy_out;
   endsequence
   sequence s_rd0;
      rd_ok && avs_address_in == 5'h00;
   endsequence
   property p_cmd_busy;
      // an abort may legally end busy early
      disable iff (!rst_b_in || sys_reset_pulse_in || abort_irq_in)
      s_cmd |=> busy_out [*8];
   endproperty
   property p_rd_busy;
      s_rd0 ##0 (busy_out && $past(busy_out) && $past(busy_out, 2)) |-> !avs_readdata_out[0];
   endproperty
   property p_rd_idle;
      s_rd0 ##0 (!busy_out && !$past(busy_out) && !$past(busy_out, 2)) |-> avs_readdata_out[0];
   endproperty
   property p_clr;
      s_rd0 ##0 clr_q |-> avs_readdata_out[7:6] == 2'b00;
   endproperty
   property p_abort_rst;
      busy_out && sys_reset_pulse_in |=> !busy_out;
   endproperty
   property p_abort_irq;
      busy_out && abort_irq_in |=> $fell(busy_out);
   endproperty
   property p_force;
      rwen_q |-> area_expansion_out && area_access_sel_out;
   endproperty
   property p_hold;
      !rwen_q |-> area_expansion_out == exp_q && area_access_sel_out == sel_q;
   endproperty
   property p_rd_wait;
      $rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
   endproperty
   a_cmd_busy: assert property (p_cmd_busy) else $error("no busy after command");
   a_rd_busy: assert property (p_rd_busy) else $error("ready read 1 while busy");
   a_rd_idle: assert property (p_rd_idle) else $error("ready read 0 while idle");
   a_clr: assert property (p_clr) else $error("error flag after clear");
   a_abort_rst: assert property (p_abort_rst) else $error("reset did not abort");
   a_abort_irq: assert property (p_abort_irq) else $error("irq did not abort");
   a_force: assert property (p_force) else $error("mode bits not forced");
   a_hold: assert property (p_hold) else $error("mode bits not restored");
   a_rd_wait: assert property (p_rd_wait) else $error("read wait cycle wrong");
endmodule

// >>> testbench/fci_top_bench.sv
// bench for fci_top: register traffic, commands, aborts, forced bits
// assumes fci_props bound below; reads noted in a queue, checked by a monitor
`timescale 1ns/1ps
module fci_top_bench;
   logic        clock_in = 0, rst_b_in = 0, avs_read_in = 0, avs_write_in = 0;
   logic        sys_reset_pulse_in = 0, abort_irq_in = 0, array_fail_in = 0, fl;
   logic [4:0]  avs_address_in = '0;
   logic [31:0] avs_writedata_in = '0, avs_readdata_out;
   logic [3:0]  avs_byteenable_in = 4'hf;
   logic        avs_waitrequest_out, area_expansion_out, area_access_sel_out, busy_out, irq_out;
   logic [63:0] note_q[$], n;
   int          fail_count = 0, checked = 0, cyc = 0, seed = 32'h255e7942;
   always #12.5 clock_in = ~clock_in;
   fci_top i_fci_top (.clock_in(clock_in), .rst_b_in(rst_b_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .sys_reset_pulse_in(sys_reset_pulse_in),
      .abort_irq_in(abort_irq_in), .array_fail_in(array_fail_in),
      .area_expansion_out(area_expansion_out), .area_access_sel_out(area_access_sel_out),
      .busy_out(busy_out), .irq_out(irq_out));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // taken at the rising edge where waitrequest is seen low
   always @(posedge clock_in) begin
      if (avs_read_in && avs_waitrequest_out === 1'b0 && note_q.size() > 0) begin
         n = note_q.pop_front();
         check(avs_readdata_out & n[63:32], n[31:0]);
      end
   end
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up;
      end
   end
   task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_read_in <= rd;
      avs_write_in <= !rd;
      do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      note_q.push_back({m, e});
      bus(1'b1, a, $random(seed));
   endtask
   task automatic pin(input int w, input logic [1:0] e);
      @(negedge clock_in);
      check(w == 0 ? busy_out : w == 1 ? irq_out : {area_expansion_out, area_access_sel_out}, e);
      @(posedge clock_in);
   endtask
   task automatic pulse(input logic rst);
      if (rst) sys_reset_pulse_in <= 1'b1;
      else abort_irq_in <= 1'b1;
      @(posedge clock_in);
      {sys_reset_pulse_in, abort_irq_in} <= 2'b00;
      pin(0, 0);
   endtask
   initial begin
      repeat (16) @(posedge clock_in);
      rst_b_in <= 1'b1;
      @(posedge clock_in);
      rd(5'h00, 32'hff, 32'h01);
      rd(5'h18, 32'hffffffff, 32'h0);
      bus(1'b0, 5'h10, 32'h7);
      for (int c = 1; c < 6; c++) begin
         fl = 1'($random(seed));
         array_fail_in <= fl;
         bus(1'b0, 5'h04, 32'(c));
         pin(0, 1);
         rd(5'h00, 32'h1, 32'h0);
         while (busy_out !== 1'b0) @(posedge clock_in);
         rd(5'h00, 32'hcf, {fl & (c == 2 || c == 5), fl & (c == 1 || c == 3), 6'h01});
         pin(1, 1);
         bus(1'b0, 5'h0c, 32'h7);
         pin(1, 0);
         bus(1'b0, 5'h04, 32'h6);
         rd(5'h00, 32'hcf, 32'h01);
         $display("command %0d done", c);
      end
      bus(1'b0, 5'h04, 32'h2);
      rd(5'h00, 32'h1, 32'h0);
      pulse(1'b0);
      rd(5'h0c, 32'h2, 32'h2);
      bus(1'b0, 5'h0c, 32'h7);
      // aborted block erased again, not programmed
      bus(1'b0, 5'h04, 32'h2);
      pulse(1'b1);
      rd(5'h00, 32'h1, 32'h1);
      $display("abort tests done");
      // bench acts as cpu code held in ram
      bus(1'b0, 5'h08, 32'h8);
      bus(1'b0, 5'h00, 32'h2);
      pin(2, 3);
      rd(5'h08, 32'h9, 32'h9);
      bus(1'b0, 5'h08, 32'h0);
      rd(5'h08, 32'h9, 32'h9);
      // read modes only once no command runs
      bus(1'b0, 5'h00, 32'hc);
      rd(5'h00, 32'hcf, 32'h0d);
      pin(2, 0);
      $display("rewrite tests done");
      wrap_up;
   end
endmodule
bind fci_top fci_props i_fci_props (.clock_in(clock_in), .rst_b_in(rst_b_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .sys_reset_pulse_in(sys_reset_pulse_in), .abort_irq_in(abort_irq_in),
   .area_expansion_out(area_expansion_out), .area_access_sel_out(area_access_sel_out),
   .busy_out(busy_out));
